// ==== hw/tcg_regs.sv ====
// Host control registers of the touch controller behind an I2C slave port.
// Assumes pins come from pads (synchronised here), the rest from clk logic.
`include "tcg_defs.svh"
`default_nettype none
module tcg_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2B
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // I2C pins, open drain
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output var  logic                sda_o,
  output var  logic                sda_oe,
  // Sensing core
  input  wire logic                comp_done,
  output var  logic                comp_start,
  output var  logic [1:0]          op_mode,
  // Lighting
  input  wire tcg_pkg::tcg_light_t light_cfg,
  output var  logic [7:0]          pin_lit,
  output var  tcg_pkg::tcg_levels_t pwm_level,
  // Parameter memory and chip events
  output var  logic                shadow_wr_done,
  output var  logic                burn_start,
  output var  logic                chip_reset
);
  import tcg_pkg::*;

  function automatic logic wr_at(input logic stb, input logic [7:0] p, input logic [7:0] a);
    wr_at = stb && (p == a);
  endfunction

  function automatic tcg_levels_t init_levels(input tcg_light_t c);
    tcg_levels_t v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      v[i] = c.power_up_output_state[i] ? c.lit_intensity_level : c.unlit_intensity_level;
    end
    init_levels = v;
  endfunction

  // Pin synchronisers; stage 0 feeds stage 1 only
  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic       scl_d_r;
  logic       sda_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else if (ce) begin
      scl_sy_r <= {scl_sy_r[0], scl_i};
      sda_sy_r <= {sda_sy_r[0], sda_i};
      scl_d_r  <= scl_sy_r[1];
      sda_d_r  <= sda_sy_r[1];
    end
  end

  wire logic scl_s     = scl_sy_r[1];
  wire logic sda_s     = sda_sy_r[1];
  wire logic start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire logic stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire logic scl_rise  = scl_s & ~scl_d_r;
  wire logic scl_fall  = ~scl_s & scl_d_r;

  tcg_state_t  st_r, st_nxt;
  tcg_kind_t   kind_r, kind_nxt;
  logic        rw_r, rw_nxt;
  logic        ph_r, ph_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        oe_r, oe_nxt;
  logic        sda_o_r;
  logic [7:0]  ptr_r;
  logic [7:0]  rd_byte;

  // Register state
  logic        init_r;
  logic        comp_run_r;
  logic        comp_start_r;
  logic [1:0]  mode_r;
  logic [7:0]  onoff_r;
  logic [7:0]  pin_lit_r;
  logic [2:0]  sel_r;
  tcg_levels_t intens_r;
  logic [1:0]  gw_en_r;
  logic        gw_dir_r;
  logic [7:0]  base_r;
  logic [7:0]  key_hi_r;
  logic [7:0]  key_lo_r;
  logic [1:0]  burn_step_r, burn_step_nxt;
  logic        burn_start_r;
  logic        shadow_pend_r;
  logic        shadow_evt_r;
  logic [7:0]  srst_val_r;
  logic        srst_arm_r;
  logic        chip_reset_r;
  logic [7:0]  mem_rdata;

  wire logic [7:0] rx_byte = {sh_r[6:0], sda_s};
  wire logic rx_done = (st_r == TCG_RXB) && scl_rise && (cnt_r == 3'h7);
  wire logic dev_hit = (rx_byte[7:1] == SLAVE_ADDR);
  wire logic wr_stb  = rx_done && (kind_r == TCG_K_DAT);
  wire logic [7:0] wdata = rx_byte;
  wire logic tx_load = scl_fall && ph_r &&
                       (((st_r == TCG_ACK) && rw_r) || (st_r == TCG_TACK));

  // Byte-level I2C slave; START and STOP override any state
  always_comb begin
    st_nxt   = st_r;
    kind_nxt = kind_r;
    rw_nxt   = rw_r;
    ph_nxt   = ph_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    oe_nxt   = oe_r;
    case (st_r)
      TCG_IDLE: ;
      TCG_RXB: if (scl_rise) begin
        sh_nxt  = rx_byte;
        cnt_nxt = 3'(cnt_r + 3'h1);
        if (cnt_r == 3'h7) begin
          st_nxt = TCG_ACK;
          ph_nxt = 1'b0;
          if (kind_r == TCG_K_DEV) begin
            rw_nxt = rx_byte[0];
            if (!dev_hit) st_nxt = TCG_IDLE;
          end
        end
      end
      TCG_ACK: if (scl_fall) begin
        ph_nxt = 1'b1;
        oe_nxt = ~ph_r;
        if (ph_r) begin
          cnt_nxt = 3'h0;
          if (rw_r) begin
            st_nxt = TCG_TXB;
            sh_nxt = rd_byte;
            oe_nxt = ~rd_byte[7];
          end else begin
            st_nxt   = TCG_RXB;
            kind_nxt = (kind_r == TCG_K_DEV) ? TCG_K_PTR : TCG_K_DAT;
          end
        end
      end
      TCG_TXB: if (scl_fall) begin
        cnt_nxt = 3'(cnt_r + 3'h1);
        sh_nxt  = {sh_r[6:0], 1'b0};
        oe_nxt  = ~sh_r[6];
        if (cnt_r == 3'h7) begin
          st_nxt = TCG_TACK;
          ph_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      end
      TCG_TACK: if (scl_rise && !ph_r) begin
        ph_nxt = 1'b1;
        if (sda_s) st_nxt = TCG_IDLE;
      end else if (scl_fall && ph_r) begin
        st_nxt  = TCG_TXB;
        cnt_nxt = 3'h0;
        sh_nxt  = rd_byte;
        oe_nxt  = ~rd_byte[7];
      end
      default: st_nxt = TCG_IDLE;
    endcase
    if (start_det) begin
      st_nxt   = TCG_RXB;
      kind_nxt = TCG_K_DEV;
      cnt_nxt  = 3'h0;
      oe_nxt   = 1'b0;
    end else if (stop_det) begin
      st_nxt = TCG_IDLE;
      oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= TCG_IDLE;
      kind_r  <= TCG_K_DEV;
      rw_r    <= 1'b0;
      ph_r    <= 1'b0;
      cnt_r   <= 3'h0;
      sh_r    <= 8'h00;
      oe_r    <= 1'b0;
      sda_o_r <= 1'b0;
      ptr_r   <= 8'h00;
    end else if (ce) begin
      st_r    <= st_nxt;
      kind_r  <= kind_nxt;
      rw_r    <= rw_nxt;
      ph_r    <= ph_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      oe_r    <= oe_nxt;
      sda_o_r <= 1'b0;
      // Pointer advances after each data byte written, and as each byte to send is loaded
      if (rx_done && (kind_r == TCG_K_PTR)) ptr_r <= rx_byte;
      else if (wr_stb || tx_load) ptr_r <= 8'(ptr_r + 8'h01);
    end
  end

  // Address map: gateway window first, control registers otherwise
  wire logic gw_on  = (gw_en_r == `TCG_GW_ON);
  wire logic gw_hit = gw_on && (ptr_r < `TCG_GW_SPAN);
  wire logic wr_reg = wr_stb && !gw_hit;
  wire logic wr_comp  = wr_at(wr_reg, ptr_r, `TCG_A_COMP);
  wire logic wr_onoff = wr_at(wr_reg, ptr_r, `TCG_A_ONOFF);
  wire logic wr_sel   = wr_at(wr_reg, ptr_r, `TCG_A_SEL);
  wire logic wr_int   = wr_at(wr_reg, ptr_r, `TCG_A_INT);
  wire logic wr_cfg   = wr_at(wr_reg, ptr_r, `TCG_A_GWCFG);
  wire logic wr_base  = wr_at(wr_reg, ptr_r, `TCG_A_GWBASE);
  wire logic wr_khi   = wr_at(wr_reg, ptr_r, `TCG_A_KEYHI);
  wire logic wr_klo   = wr_at(wr_reg, ptr_r, `TCG_A_KEYLO);
  wire logic wr_srst  = wr_at(wr_reg, ptr_r, `TCG_A_SRST);
  wire logic mem_we   = wr_stb && gw_hit && !gw_dir_r;
  wire logic [6:0] mem_addr = {base_r[6:3], ptr_r[2:0]};

  // Reserved bits read as zero; the host may not rely on them anyway
  assign rd_byte =
    gw_hit                    ? mem_rdata :
    (ptr_r == `TCG_A_COMP)   ? {5'h00, comp_run_r, mode_r} :
    (ptr_r == `TCG_A_ONOFF)  ? onoff_r :
    (ptr_r == `TCG_A_SEL)    ? {5'h00, sel_r} :
    (ptr_r == `TCG_A_INT)    ? intens_r[sel_r] :
    (ptr_r == `TCG_A_GWCFG)  ? {2'h0, gw_en_r, gw_dir_r, 3'h0} :
    (ptr_r == `TCG_A_GWBASE) ? base_r :
    (ptr_r == `TCG_A_KEYHI)  ? key_hi_r :
    (ptr_r == `TCG_A_KEYLO)  ? key_lo_r :
    (ptr_r == `TCG_A_SRST)   ? srst_val_r : 8'h00;

  tcg_shadow_mem #(
    .AW(7),
    .DW(8)
  ) u_mem (
    .clk  (clk),
    .rst_n(rst_n),
    .ce   (ce),
    .we   (mem_we),
    .addr (mem_addr),
    .wdata(wdata),
    .rdata(mem_rdata)
  );

  wire logic comp_run_nxt = (wr_comp && wdata[`TCG_COMP_BIT]) || (comp_run_r && !comp_done);
  wire logic keys_ok = (key_hi_r == `TCG_KEY_HI) && (key_lo_r == `TCG_KEY_LO);
  wire logic burn_go = stop_det && (burn_step_r == 2'h2);
  wire logic shadow_set = mem_we && (ptr_r[2:0] == `TCG_BURST_LAST);
  wire logic shadow_any = shadow_set || shadow_pend_r;
  wire logic asleep = (mode_r == `TCG_MODE_SLEEP);

  always_comb begin
    burn_step_nxt = burn_step_r;
    if (burn_go) burn_step_nxt = 2'h0;
    else if (wr_base && keys_ok && (wdata == `TCG_BURN_A)) burn_step_nxt = 2'h1;
    else if (wr_base && (burn_step_r == 2'h1) && (wdata == `TCG_BURN_B)) burn_step_nxt = 2'h2;
    else if (wr_base) burn_step_nxt = 2'h0;
  end

  // Control, mode and lighting; stored defaults load on the first enabled cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r       <= 1'b1;
      comp_run_r   <= 1'b0;
      comp_start_r <= 1'b0;
      mode_r       <= `TCG_MODE_ACT;
      onoff_r      <= 8'h00;
      pin_lit_r    <= 8'h00;
      sel_r        <= 3'h0;
      intens_r     <= '0;
    end else if (ce) begin
      init_r       <= 1'b0;
      comp_run_r   <= comp_run_nxt;
      comp_start_r <= wr_comp && wdata[`TCG_COMP_BIT];
      if (wr_comp && (wdata[1:0] != `TCG_MODE_RSVD)) mode_r <= wdata[1:0];
      if (init_r) onoff_r <= light_cfg.power_up_output_state;
      else if (wr_onoff) onoff_r <= wdata;
      if (!light_cfg.autolight) pin_lit_r <= onoff_r & light_cfg.out_mask;
      if (wr_sel) sel_r <= wdata[2:0];
      if (init_r) intens_r <= init_levels(light_cfg);
      else if (wr_int) intens_r[sel_r] <= wdata;
    end
  end

  // Gateway, burn unlock and software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gw_en_r       <= 2'h0;
      gw_dir_r      <= 1'b0;
      base_r        <= 8'h00;
      key_hi_r      <= 8'h00;
      key_lo_r      <= 8'h00;
      burn_step_r   <= 2'h0;
      burn_start_r  <= 1'b0;
      shadow_pend_r <= 1'b0;
      shadow_evt_r  <= 1'b0;
      srst_val_r    <= 8'h00;
      srst_arm_r    <= 1'b0;
      chip_reset_r  <= 1'b0;
    end else if (ce) begin
      if (wr_cfg) gw_en_r <= wdata[5:4];
      if (wr_cfg) gw_dir_r <= wdata[3];
      if (wr_base) base_r <= wdata & `TCG_BASE_MASK;
      if (burn_go) key_hi_r <= 8'h00;
      else if (wr_khi) key_hi_r <= wdata;
      if (burn_go) key_lo_r <= 8'h00;
      else if (wr_klo) key_lo_r <= wdata;
      burn_step_r   <= burn_step_nxt;
      burn_start_r  <= burn_go;
      // Sleep defers the event until doze or active
      shadow_pend_r <= shadow_any && asleep;
      shadow_evt_r  <= shadow_any && !asleep;
      if (wr_srst) srst_val_r <= wdata;
      if (wr_srst) srst_arm_r <= (wdata == `TCG_SRST_ARM);
      chip_reset_r  <= wr_srst && srst_arm_r && (wdata == `TCG_SRST_GO);
    end
  end

  assign sda_o          = sda_o_r;
  assign sda_oe         = oe_r;
  assign comp_start     = comp_start_r;
  assign op_mode        = mode_r;
  assign pin_lit        = pin_lit_r;
  assign pwm_level      = intens_r;
  assign shadow_wr_done = shadow_evt_r;
  assign burn_start     = burn_start_r;
  assign chip_reset     = chip_reset_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence comp_trig_s;
    ce && wr_comp && wdata[`TCG_COMP_BIT];
  endsequence
  sequence srst_go_s;
    ce && wr_srst && srst_arm_r && (wdata == `TCG_SRST_GO);
  endsequence

  comp_start_a: assert property (comp_trig_s |=> comp_run_r && comp_start_r)
    else $error("compensation trigger not taken");
  mode_write_a: assert property (ce && wr_comp && (wdata[1:0] != `TCG_MODE_RSVD)
    |=> op_mode == $past(wdata[1:0]))
    else $error("mode write lost");
  pin_drive_a: assert property (ce && !init_r && !light_cfg.autolight
    |=> pin_lit == ($past(onoff_r) & $past(light_cfg.out_mask)))
    else $error("output pin not following on/off bit");
  pin_select_a: assert property (ce && wr_sel |=> sel_r == $past(wdata[2:0]))
    else $error("pin selector not stored");
  level_write_a: assert property (ce && wr_int && !init_r
    |=> pwm_level[$past(sel_r)] == $past(wdata))
    else $error("intensity not written to selected pin");
  level_read_a: assert property (ce && tx_load && !gw_hit && (ptr_r == `TCG_A_INT)
    |=> sh_r == $past(intens_r[sel_r]))
    else $error("intensity read from wrong pin");
  srst_pulse_a: assert property (srst_go_s |=> chip_reset ##1 (!ce || !chip_reset))
    else $error("reset sequence did not pulse");
  srst_cause_a: assert property ($rose(chip_reset) |-> $past(srst_arm_r))
    else $error("reset without arming write");
  base_align_a: assert property (base_r[2:0] == 3'h0 && base_r <= `TCG_BASE_MASK)
    else $error("base not aligned");
  gw_write_a: assert property (mem_we |-> gw_on && !gw_dir_r && ptr_r < `TCG_GW_SPAN)
    else $error("parameter write outside gateway window");
  burn_go_a: assert property ($rose(burn_start) |-> $past(keys_ok && burn_step_r == 2'h2))
    else $error("burn without unlock sequence");
  shadow_evt_a: assert property (shadow_wr_done |-> op_mode != `TCG_MODE_SLEEP)
    else $error("gateway write event during sleep");
endmodule
`default_nettype wire

// ==== hw/tcg_defs.svh ====
// Constants of the touch controller host register bank: offsets, fields, keys.
// Definitions only; included by the register bank.
`ifndef TCG_DEFS_SVH
`define TCG_DEFS_SVH
`define TCG_A_COMP     8'h09
`define TCG_A_ONOFF    8'h0A
`define TCG_A_SEL      8'h0B
`define TCG_A_INT      8'h0C
`define TCG_A_GWCFG    8'h0D
`define TCG_A_GWBASE   8'h0E
`define TCG_A_KEYHI    8'hAC
`define TCG_A_KEYLO    8'hAD
`define TCG_A_SRST     8'hB1
`define TCG_COMP_BIT   2
`define TCG_MODE_ACT   2'h0
`define TCG_MODE_SLEEP 2'h2
`define TCG_MODE_RSVD  2'h3
`define TCG_GW_ON      2'h1
`define TCG_GW_SPAN    8'h08
`define TCG_BASE_MASK  8'h78
`define TCG_BURST_LAST 3'h7
`define TCG_SRST_ARM   8'hDE
`define TCG_SRST_GO    8'h00
`define TCG_KEY_HI     8'h62
`define TCG_KEY_LO     8'h9D
`define TCG_BURN_A     8'hA5
`define TCG_BURN_B     8'h5A
`endif

// ==== hw/tcg_pkg.sv ====
// Types shared by the touch controller register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tcg_pkg;
  typedef enum logic [4:0] {
    TCG_IDLE = 5'h01,
    TCG_RXB  = 5'h02,
    TCG_ACK  = 5'h04,
    TCG_TXB  = 5'h08,
    TCG_TACK = 5'h10
  } tcg_state_t;
  typedef enum logic [1:0] {
    TCG_K_DEV = 2'h0,
    TCG_K_PTR = 2'h1,
    TCG_K_DAT = 2'h2
  } tcg_kind_t;
  typedef struct packed {
    logic [7:0] power_up_output_state;
    logic [7:0] out_mask;
    logic [7:0] lit_intensity_level;
    logic [7:0] unlit_intensity_level;
    logic       autolight;
  } tcg_light_t;
  typedef logic [7:0][7:0] tcg_levels_t;
endpackage
`default_nettype wire

// ==== hw/tcg_shadow_mem.sv ====
// Shadow parameter memory: single port, registered read data.
// Assumes the caller holds the address one cycle before using rdata.
`default_nettype none
module tcg_shadow_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(2**AW)-1];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;
endmodule
`default_nettype wire

// ==== verification/tcg_host_bfm.sv ====
// Host model: I2C bus master for the touch controller register bank.
// Assumes the bench resolves SDA as open drain with a pull-up.
`default_nettype none
module tcg_host_bfm (
  // Clock
  input  wire logic clk,
  // I2C bus
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half SCL period in clk; the port needs at least 3
  localparam int H = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Also serves as repeated start: SDA is released while SCL is low
  task automatic start();
    sda_low = 1'b0;
    idle(H);
    scl = 1'b1;
    idle(H);
    sda_low = 1'b1;
    idle(H);
    scl = 1'b0;
    idle(H);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    idle(H);
    scl = 1'b1;
    idle(H);
    sda_low = 1'b0;
    idle(4 * H);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      idle(H);
      scl = 1'b1;
      idle(H);
      scl = 1'b0;
    end
    sda_low = 1'b0;
    idle(H);
    scl = 1'b1;
    idle(H / 2);
    ack = (sda === 1'b0);
    idle(H / 2);
    scl = 1'b0;
  endtask
  // Sampled mid-high, well after the port's 3 clk output lag
  task automatic rbyte(input logic last, output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      idle(H);
      scl = 1'b1;
      idle(H / 2);
      b[i] = sda;
      idle(H / 2);
      scl = 1'b0;
    end
    sda_low = !last;
    idle(H);
    scl = 1'b1;
    idle(H);
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tcg_regs_tb_top.sv ====
// Testbench for the touch controller register bank, driven over I2C.
// Assumes the host model above and the design's package and header.
`include "tcg_defs.svh"
`default_nettype none
module tcg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tcg_pkg::*;
  localparam logic [6:0] SA = 7'h2B;
  logic        clk, rst_n, ce, comp_done, scl, sda_low;
  logic        sda_o, sda_oe, comp_start, shadow_wr_done, burn_start, chip_reset;
  wire  logic  sda;
  logic [1:0]  op_mode;
  logic [7:0]  pin_lit;
  tcg_light_t  light_cfg;
  tcg_levels_t pwm_level;
  int          n_fail = 0, num_checks = 0, n_comp = 0, n_wr = 0, n_burn = 0, n_rst = 0;
  // Pull-up wins unless someone pulls low
  assign sda = !(sda_low || (sda_oe && !sda_o));
  tcg_regs #(.SLAVE_ADDR(SA)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .comp_done(comp_done),
    .comp_start(comp_start), .op_mode(op_mode), .light_cfg(light_cfg),
    .pin_lit(pin_lit), .pwm_level(pwm_level), .shadow_wr_done(shadow_wr_done),
    .burn_start(burn_start), .chip_reset(chip_reset));
  tcg_host_bfm i_host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    n_comp <= n_comp + int'(comp_start === 1'b1);
    n_wr <= n_wr + int'(shadow_wr_done === 1'b1);
    n_burn <= n_burn + int'(burn_start === 1'b1);
    n_rst <= n_rst + int'(chip_reset === 1'b1);
  end
  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    i_host.start();
    i_host.wbyte({SA, 1'b0}, k);
    i_host.wbyte(a, k);
    i_host.wbyte(d, k);
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    i_host.start();
    i_host.wbyte({SA, 1'b0}, k);
    i_host.wbyte(a, k);
    i_host.start();
    i_host.wbyte({SA, 1'b1}, k);
    i_host.rbyte(1'b1, d);
    i_host.stop();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    logic [7:0] v;
    rst_n = 1'b0;
    ce = 1'b1;
    comp_done = 1'b0;
    light_cfg = '{8'hA5, 8'h0F, 8'hC8, 8'h11, 1'b0};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    i_host.idle(5);
    chk(pin_lit, 8'h05);
    for (int i = 0; i < 8; i++)
      chk(pwm_level[i], light_cfg.power_up_output_state[i] ? 8'hC8 : 8'h11);
    rdc(`TCG_A_ONOFF, 8'hA5);
    rdc(`TCG_A_SEL, 8'h00);
    rdc(`TCG_A_INT, 8'hC8);
    rdc(`TCG_A_GWCFG, 8'h00);
    rdc(`TCG_A_GWBASE, 8'h00);
    // Upper bits of the mode register read as zero; only 2:0 is compared
    rd(`TCG_A_COMP, v);
    chk(v & 8'h07, 8'h00);
    wr(`TCG_A_COMP, 8'h04);
    chk(8'(n_comp), 8'h01);
    rd(`TCG_A_COMP, v);
    chk(v & 8'h07, 8'h04);
    comp_done = 1'b1;
    @(negedge clk);
    comp_done = 1'b0;
    rd(`TCG_A_COMP, v);
    chk(v & 8'h07, 8'h00);
    wr(`TCG_A_ONOFF, 8'h3C);
    chk(pin_lit, 8'h0C);
    light_cfg.autolight = 1'b1;
    wr(`TCG_A_ONOFF, 8'hFF);
    chk(pin_lit, 8'h0C);
    light_cfg.autolight = 1'b0;
    i_host.idle(2);
    chk(pin_lit, 8'h0F);
    for (int i = 0; i < 8; i++) begin
      wr(`TCG_A_SEL, 8'(i));
      wr(`TCG_A_INT, {i[2:0], 5'h1F});
    end
    for (int i = 0; i < 8; i++) begin
      wr(`TCG_A_SEL, 8'(i));
      rdc(`TCG_A_INT, {i[2:0], 5'h1F});
      chk(pwm_level[i], {i[2:0], 5'h1F});
    end
    wr(`TCG_A_SRST, 8'hDE);
    wr(`TCG_A_SRST, 8'h00);
    chk(8'(n_rst), 8'h01);
    wr(`TCG_A_SRST, 8'hDE);
    wr(`TCG_A_SRST, 8'h11);
    wr(`TCG_A_SRST, 8'h00);
    chk(8'(n_rst), 8'h01);
    wr(`TCG_A_GWCFG, 8'h10);
    wr(`TCG_A_GWBASE, 8'h18);
    for (int i = 0; i < 8; i++)
      wr(8'(i), 8'h40 + 8'(i));
    chk(8'(n_wr), 8'h01);
    wr(`TCG_A_GWCFG, 8'h00);
    rdc(8'h03, 8'h00);
    wr(`TCG_A_GWCFG, 8'h18);
    rdc(`TCG_A_GWCFG, 8'h18);
    // A write in read direction must leave the memory alone
    wr(8'h00, 8'hEE);
    for (int i = 0; i < 8; i++)
      rdc(8'(i), 8'h40 + 8'(i));
    wr(`TCG_A_GWCFG, 8'h00);
    wr(`TCG_A_KEYHI, 8'h62);
    rdc(`TCG_A_KEYHI, 8'h62);
    wr(`TCG_A_KEYLO, 8'h9D);
    rdc(`TCG_A_KEYLO, 8'h9D);
    wr(`TCG_A_GWBASE, 8'hA5);
    wr(`TCG_A_GWBASE, 8'h5A);
    chk(8'(n_burn), 8'h01);
    rdc(`TCG_A_GWBASE, 8'h58);
    wr(`TCG_A_GWBASE, 8'hA5);
    wr(`TCG_A_GWBASE, 8'h5A);
    chk(8'(n_burn), 8'h01);
    // Modes last and checked at the port: no read follows a wake-up
    for (int m = 1; m < 3; m++) begin
      wr(`TCG_A_COMP, 8'(m));
      chk({6'h00, op_mode}, 8'(m));
    end
    wr(`TCG_A_COMP, 8'h03);
    chk({6'h00, op_mode}, 8'h02);
    chk(8'(n_comp), 8'h01);
    // Gateway write in sleep: the event waits for the wake-up
    wr(`TCG_A_GWCFG, 8'h10);
    wr(`TCG_A_GWBASE, 8'h08);
    for (int i = 0; i < 8; i++)
      wr(8'(i), 8'h80 + 8'(i));
    chk(8'(n_wr), 8'h01);
    wr(`TCG_A_GWCFG, 8'h00);
    wr(`TCG_A_COMP, 8'h00);
    chk(8'(n_wr), 8'h02);
    // Clock enable low freezes the output pins
    ce = 1'b0;
    light_cfg.out_mask = 8'hF0;
    i_host.idle(4);
    chk(pin_lit, 8'h0F);
    ce = 1'b1;
    i_host.idle(2);
    chk(pin_lit, 8'hF0);
    results();
  end
endmodule
`default_nettype wire
